// ==== include/tsc_defines.svh ====
// Register map, field positions, reset values and timing counts of the traverse control.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
`define TSC_ADDR_CTRL 32'h00000000
`define TSC_ADDR_CFG 32'h00000004
`define TSC_ADDR_FUNC 32'h00000008
`define TSC_ADDR_EXTERR 32'h0000000C
`define TSC_ADDR_TARGET 32'h00000010
`define TSC_ADDR_RANGE 32'h00000014
`define TSC_ADDR_CHGDIFF 32'h00000018
`define TSC_ADDR_STATUS 32'h0000001C
`define TSC_ADDR_ACTPOS 32'h00000020
`define TSC_CTRL_START 0
`define TSC_CTRL_STOP 1
`define TSC_CTRL_RESUME 2
`define TSC_CTRL_JOGF 3
`define TSC_CTRL_JOGR 4
`define TSC_CTRL_JOGMODE 5
`define TSC_CTRL_CREEP 6
`define TSC_CTRL_HOST 7
`define TSC_CTRL_RESET 32'h00000000
`define TSC_CFG_EDGE 0
`define TSC_CFG_RESP_LO 1
`define TSC_CFG_RESP_HI 2
`define TSC_CFG_DRVDIS 3
`define TSC_CFG_CAMEN 4
`define TSC_CFG_RESET 32'h00000010
`define TSC_RESP_IGNORE 2'h0
`define TSC_RESP_OUTOFF 2'h1
`define TSC_RESP_DRVDIS 2'h2
`define TSC_RESP_CAMOFF 2'h3
`define TSC_FUNC_INVALID 0
`define TSC_EXT_CODE_HI 4
`define TSC_EXT_LIMFWD 5
`define TSC_EXT_NONE 5'h00
`define TSC_EXT_SUPPLY_DI 5'h02
`define TSC_EXT_SUPPLY_ENC24 5'h07
`define TSC_EXT_SUPPLY_ENC5 5'h08
`define TSC_EXT_ENC_SIGNAL 5'h0A
`define TSC_EXT_ZERO_MARK 5'h0B
`define TSC_EXT_WORK_RANGE 5'h0D
`define TSC_EXT_NO_MOTION 5'h0F
`define TSC_EXT_ZERO_SPEED 5'h11
`define TSC_EXT_REDUCTION 5'h12
`define TSC_ST_POSREACH 4
`define TSC_ST_FICTREACH 5
`define TSC_ST_OPERR 6
`define TSC_ST_UNSYNC 9
`define TSC_ST_HALT 8
`define TSC_ST_HOST 10
`define TSC_READY_LOSS_US 4500000
`define TSC_CLK_MHZ 250
`define TSC_READY_LOSS_CYC (`TSC_READY_LOSS_US * `TSC_CLK_MHZ)
`endif

// ==== include/tsc_pkg.sv ====
// Types shared by the traverse control design.
package tsc_pkg;
   typedef enum logic [3:0] {
      ST_DONE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_RUN = 4'b0100,
      ST_INTR = 4'b1000
   } tsc_state_t;
endpackage

// ==== logic/tsc_traverse_ctrl.sv ====
// Traverse state control of one positioning axis with an APB register slave.
// Overview of operation
// - Mode is completed, waiting, running or interrupted; leaving running stops drive.
// - Level coordination: start needs start bit and gate input high.
// - Level coordination: stop bit or gate low interrupts running mode.
// - Level coordination: resume needs resume bit and gate input high.
// - Level jog: a direction bit and gate high start jogging.
// - Level jog: no direction bit or gate low completes jogging.
// - Edge coordination: start/resume need gate rising; stop or gate rise interrupts.
// - Edge jog: direction bit plus gate rise starts; cleared bits or rise complete.
// - Interrupt or completion by the gate input switches the drive off.
// - Operator error steps running to interrupted, interrupted to completed, flags it.
// - Pending external error aborts running or interrupted mode to completed.
// - Creep jog stays allowed for external errors 2,7,8,10,11,13,15,17,18.
// - With error 13 creep jog only toward the tripped software limit.
// - Internal module fault halts the block permanently.
// - Switch to host control interrupts running mode; armed settings are kept.
// - Power fail halts, drives outputs off, marks unsynced, restarts on return.
// - Host failure is seen by output disable or loss of cyclic ready.
// - Output disable response is configurable: off, drive disable, cam off, ignore.
// - About 4.5 s without cyclic ready forces programmer control mode.
// - Entering the target range finishes the mode and raises position reached.
// - Position reached holds until a new externally enabled start.
// - Stops latch a fictitious range around position shifted by changeover difference in travel direction.
// - Invalid functions raise operator error unless completed; valid ones are not stored.
// - Drive disable aborts any mode in any state.
//
// The register offsets and the APB slave port were chosen for this implementation.
`include "tsc_defines.svh"
module tsc_traverse_ctrl #(
   parameter int unsigned READY_LOSS_CYC = `TSC_READY_LOSS_CYC
) (
   input logic core_clk,
   input logic srst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input logic [31:0] actPos,
   input logic moduleFault,
   input logic axisSyncGateInput,
   input logic outputDisableSignal,
   input logic powerFailSignalN,
   input logic hostCyclicReady,
   output logic driveOn,
   output logic driveFwd,
   output logic driveRev,
   output logic driveCreep,
   output logic driveDisable,
   output logic camTrackEnable,
   output logic positionReached,
   output tsc_pkg::tsc_state_t modeState
);
   import tsc_pkg::*;

   function automatic logic inRange(input logic [31:0] a, input logic [31:0] b,
                                    input logic [31:0] r);
      logic signed [32:0] d;
      d = $signed({a[31], a}) - $signed({b[31], b});
      if (d < 0) begin
         d = -d;
      end
      return d <= $signed({1'b0, r});
   endfunction

   function automatic logic creepAllowed(input logic [4:0] code, input logic f,
                                         input logic r, input logic limFwd);
      creepAllowed = 1'b0;
      unique case (code)
         `TSC_EXT_SUPPLY_DI, `TSC_EXT_SUPPLY_ENC24, `TSC_EXT_SUPPLY_ENC5,
         `TSC_EXT_ENC_SIGNAL, `TSC_EXT_ZERO_MARK, `TSC_EXT_NO_MOTION,
         `TSC_EXT_ZERO_SPEED, `TSC_EXT_REDUCTION: creepAllowed = 1'b1;
         `TSC_EXT_WORK_RANGE: creepAllowed = limFwd ? (f & !r) : (r & !f);
         default: creepAllowed = 1'b0;
      endcase
   endfunction

   // Pin inputs: {ready, power good, output disable, gate}.
   logic [3:0] pinMeta_reg;
   logic [3:0] pinSync_reg;
   logic [3:0] pinPrev_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pinMeta_reg <= 4'h4;
         pinSync_reg <= 4'h4;
         pinPrev_reg <= 4'h4;
      end else begin
         pinMeta_reg <= {hostCyclicReady, powerFailSignalN, outputDisableSignal,
                         axisSyncGateInput};
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   wire gateLvl = pinSync_reg[0];
   wire gateRise = pinSync_reg[0] & !pinPrev_reg[0];
   wire hostOff = pinSync_reg[1];
   wire pfActive = !pinSync_reg[2];
   wire pfEnd = pinSync_reg[2] & !pinPrev_reg[2];
   wire readyEdge = pinSync_reg[3] ^ pinPrev_reg[3];
   // A return from power failure restarts the module logic.
   wire rstInt = srst | pfEnd;

   // APB slave.
   logic preadyReg;
   logic [31:0] prdataReg;
   logic pslverrReg;
   logic [31:0] ctrl_reg;
   logic [31:0] cfg_reg;
   logic [5:0] ext_reg;
   logic [31:0] target_reg;
   logic [31:0] range_reg;
   logic [31:0] chg_reg;
   logic [31:0] fict_reg;
   tsc_state_t state_reg;
   tsc_state_t state_next;
   logic posReach_reg;
   logic fictArm_reg;
   logic fictReach_reg;
   logic opErr_reg;
   logic halt_reg;
   logic unsync_reg;
   logic hostPrev_reg;
   logic dirFwd_reg;
   logic readySeen_reg;
   logic [31:0] readyCnt_reg;
   logic driveOn_reg;
   logic driveFwd_reg;
   logic driveRev_reg;
   logic driveCreep_reg;
   logic driveDis_reg;
   logic camEn_reg;

   wire apbAcc = psel & penable & preadyReg;
   wire apbWr = apbAcc & pwrite;
   wire hitCtrl = paddr == `TSC_ADDR_CTRL;
   wire hitCfg = paddr == `TSC_ADDR_CFG;
   wire hitFunc = paddr == `TSC_ADDR_FUNC;
   wire hitExt = paddr == `TSC_ADDR_EXTERR;
   wire hitTgt = paddr == `TSC_ADDR_TARGET;
   wire hitRange = paddr == `TSC_ADDR_RANGE;
   wire hitChg = paddr == `TSC_ADDR_CHGDIFF;
   wire hitStat = paddr == `TSC_ADDR_STATUS;
   wire hitPos = paddr == `TSC_ADDR_ACTPOS;
   wire mapped = hitCtrl | hitCfg | hitFunc | hitExt | hitTgt | hitRange | hitChg
                 | hitStat | hitPos;
   wire wrStat = apbWr & hitStat;
   wire wrFunc = apbWr & hitFunc;

   wire [31:0] statusWord = {20'h00000, driveOn_reg, ctrl_reg[`TSC_CTRL_HOST], unsync_reg,
                             halt_reg, ext_reg[`TSC_EXT_CODE_HI:0] != `TSC_EXT_NONE,
                             opErr_reg, fictReach_reg, posReach_reg, state_reg};
   wire [31:0] rdMux = hitCtrl ? ctrl_reg :
                       hitCfg ? cfg_reg :
                       hitExt ? {26'h0000000, ext_reg} :
                       hitTgt ? target_reg :
                       hitRange ? range_reg :
                       hitChg ? chg_reg :
                       hitStat ? statusWord :
                       hitPos ? actPos : 32'h00000000;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         preadyReg <= 1'b0;
         prdataReg <= 32'h00000000;
         pslverrReg <= 1'b0;
      end else begin
         preadyReg <= psel & penable & !preadyReg;
         prdataReg <= (psel & !pwrite) ? rdMux : 32'h00000000;
         pslverrReg <= psel & penable & !preadyReg & !mapped;
      end
   end

   // Host cyclic ready watchdog.
   wire readyLost = readySeen_reg & (readyCnt_reg == READY_LOSS_CYC);
   always_ff @(posedge core_clk) begin
      if (rstInt) begin
         readySeen_reg <= 1'b0;
         readyCnt_reg <= 32'h00000000;
      end else if (readyEdge) begin
         readySeen_reg <= 1'b1;
         readyCnt_reg <= 32'h00000000;
      end else if (readySeen_reg && !readyLost) begin
         readyCnt_reg <= readyCnt_reg + 32'h00000001;
      end
   end

   // Setup registers; parameter writes apply at once while a traverse runs.
   always_ff @(posedge core_clk) begin
      if (rstInt) begin
         ctrl_reg <= `TSC_CTRL_RESET;
         cfg_reg <= `TSC_CFG_RESET;
         ext_reg <= 6'h00;
         target_reg <= 32'h00000000;
         range_reg <= 32'h00000000;
         chg_reg <= 32'h00000000;
      end else begin
         if (apbWr && hitCtrl) begin
            ctrl_reg <= pwdata;
         end
         if (readyLost) begin
            ctrl_reg[`TSC_CTRL_HOST] <= 1'b0;
         end
         if (apbWr && hitCfg) begin
            cfg_reg <= pwdata;
         end
         if (apbWr && hitExt) begin
            ext_reg <= pwdata[`TSC_EXT_LIMFWD:0];
         end
         if (apbWr && hitTgt) begin
            target_reg <= pwdata;
         end
         if (apbWr && hitRange) begin
            range_reg <= pwdata;
         end
         if (apbWr && hitChg) begin
            chg_reg <= pwdata;
         end
      end
   end

   wire startBit = ctrl_reg[`TSC_CTRL_START];
   wire stopBit = ctrl_reg[`TSC_CTRL_STOP];
   wire resumeBit = ctrl_reg[`TSC_CTRL_RESUME];
   wire jogF = ctrl_reg[`TSC_CTRL_JOGF];
   wire jogR = ctrl_reg[`TSC_CTRL_JOGR];
   wire jogMode = ctrl_reg[`TSC_CTRL_JOGMODE];
   wire creepBit = ctrl_reg[`TSC_CTRL_CREEP];
   wire hostMode = ctrl_reg[`TSC_CTRL_HOST];
   wire edgeMode = cfg_reg[`TSC_CFG_EDGE];
   wire [1:0] resp = cfg_reg[`TSC_CFG_RESP_HI:`TSC_CFG_RESP_LO];
   wire anyJog = jogF | jogR;
   wire [4:0] extCode = ext_reg[`TSC_EXT_CODE_HI:0];
   wire extPend = extCode != `TSC_EXT_NONE;
   wire creepOk = creepBit & creepAllowed(extCode, jogF, jogR, ext_reg[`TSC_EXT_LIMFWD]);
   wire jogPermit = !extPend | creepOk;
   wire gateOk = edgeMode ? gateRise : gateLvl;
   wire gateStop = edgeMode ? gateRise : !gateLvl;
   wire hostDown = hostOff & (resp != `TSC_RESP_IGNORE);
   wire outOff = pfActive | halt_reg | (hostOff & (resp == `TSC_RESP_OUTOFF));
   wire drvDisReq = cfg_reg[`TSC_CFG_DRVDIS] | (hostOff & (resp == `TSC_RESP_DRVDIS));
   wire blockAll = outOff | hostDown | drvDisReq;
   wire tgtHit = inRange(actPos, target_reg, range_reg);
   wire isRun = state_reg == ST_RUN;
   wire creepRun = isRun & jogMode & creepOk;
   wire extAbort = extPend & (isRun | (state_reg == ST_INTR)) & !creepRun;
   wire opErrEvt = wrFunc & pwdata[`TSC_FUNC_INVALID] & (state_reg != ST_DONE);
   wire hostRise = hostMode & !hostPrev_reg;
   wire tgtDone = isRun & !jogMode & tgtHit;
   wire startEvt = (state_next == ST_RUN) & !isRun & (state_reg != ST_INTR);
   wire stopEvt = isRun & (state_next != ST_RUN) & !tgtDone;
   wire dirNext = jogMode ? jogF : ($signed(target_reg) > $signed(actPos));

   always_comb begin
      state_next = state_reg;
      if (blockAll || moduleFault) begin
         state_next = ST_DONE;
      end else if (extAbort) begin
         state_next = ST_DONE;
      end else if (opErrEvt) begin
         state_next = isRun ? ST_INTR : ST_DONE;
      end else if (hostRise && isRun) begin
         state_next = ST_INTR;
      end else begin
         unique case (state_reg)
            ST_DONE: begin
               if (jogMode) begin
                  if (anyJog && gateOk && jogPermit) begin
                     state_next = ST_RUN;
                  end
               end else if (startBit && !stopBit && !extPend) begin
                  state_next = gateOk ? ST_RUN : ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!startBit) begin
                  state_next = ST_DONE;
               end else if (gateOk && !stopBit) begin
                  state_next = ST_RUN;
               end
            end
            ST_RUN: begin
               if (jogMode) begin
                  if (!anyJog || gateStop) begin
                     state_next = ST_DONE;
                  end
               end else if (tgtHit) begin
                  state_next = ST_DONE;
               end else if (stopBit || gateStop) begin
                  state_next = ST_INTR;
               end
            end
            ST_INTR: begin
               if (resumeBit && gateOk && !stopBit) begin
                  state_next = ST_RUN;
               end
            end
         endcase
      end
   end

   // Mode state and indications.
   always_ff @(posedge core_clk) begin
      if (rstInt) begin
         state_reg <= ST_DONE;
         posReach_reg <= 1'b0;
         fictArm_reg <= 1'b0;
         fictReach_reg <= 1'b0;
         fict_reg <= 32'h00000000;
         opErr_reg <= 1'b0;
         hostPrev_reg <= 1'b0;
         dirFwd_reg <= 1'b0;
      end else if (!halt_reg) begin
         state_reg <= state_next;
         hostPrev_reg <= hostMode;
         if (isRun) begin
            dirFwd_reg <= dirNext;
         end
         if (tgtDone) begin
            posReach_reg <= 1'b1;
         end else if (startEvt) begin
            posReach_reg <= 1'b0;
         end
         if (stopEvt) begin
            fict_reg <= dirFwd_reg ? actPos + chg_reg : actPos - chg_reg;
            fictArm_reg <= 1'b1;
            fictReach_reg <= 1'b0;
         end else if (startEvt) begin
            fictArm_reg <= 1'b0;
            fictReach_reg <= 1'b0;
         end else if (fictArm_reg && inRange(actPos, fict_reg, range_reg)) begin
            fictReach_reg <= 1'b1;
         end
         if (opErrEvt) begin
            opErr_reg <= 1'b1;
         end else if (wrStat && pwdata[`TSC_ST_OPERR]) begin
            opErr_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         halt_reg <= 1'b0;
         unsync_reg <= 1'b0;
      end else begin
         if (moduleFault) begin
            halt_reg <= 1'b1;
         end
         if (pfActive) begin
            unsync_reg <= 1'b1;
         end else if (wrStat && pwdata[`TSC_ST_UNSYNC]) begin
            unsync_reg <= 1'b0;
         end
      end
   end

   // Drive outputs; the drive runs only in the running state.
   // A module restart forces the mode to completed, so the drive must not start with it.
   wire driveNext = (state_next == ST_RUN) & !blockAll & !moduleFault & !pfEnd;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         driveOn_reg <= 1'b0;
         driveFwd_reg <= 1'b0;
         driveRev_reg <= 1'b0;
         driveCreep_reg <= 1'b0;
         driveDis_reg <= 1'b0;
         camEn_reg <= 1'b0;
      end else begin
         driveOn_reg <= driveNext;
         driveFwd_reg <= driveNext & dirNext;
         driveRev_reg <= driveNext & !dirNext;
         driveCreep_reg <= driveNext & creepBit;
         driveDis_reg <= drvDisReq & !pfActive;
         camEn_reg <= cfg_reg[`TSC_CFG_CAMEN] & !outOff
                      & !(hostOff & (resp == `TSC_RESP_CAMOFF));
      end
   end

   assign pready = preadyReg;
   assign prdata = prdataReg;
   assign pslverr = pslverrReg;
   assign driveOn = driveOn_reg;
   assign driveFwd = driveFwd_reg;
   assign driveRev = driveRev_reg;
   assign driveCreep = driveCreep_reg;
   assign driveDisable = driveDis_reg;
   assign camTrackEnable = camEn_reg;
   assign positionReached = posReach_reg;
   assign modeState = state_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   drive_state_a: assert property (state_reg != ST_RUN |-> !driveOn_reg)
      else $error("Drive on outside running state.");
   level_start_a: assert property (state_reg == ST_DONE && !edgeMode && !jogMode && startBit
      && !stopBit && gateLvl && !extPend && !blockAll && !moduleFault && !halt_reg && !pfEnd
      |=> state_reg == ST_RUN && driveOn_reg)
      else $error("Level start did not run.");
   level_intr_a: assert property (isRun && !edgeMode && !gateLvl && !halt_reg && !pfEnd
      |=> state_reg != ST_RUN ##0 !driveOn_reg)
      else $error("Gate low did not stop traverse.");
   resume_a: assert property (state_reg == ST_INTR && !edgeMode && resumeBit && !stopBit
      && gateLvl && !blockAll && !extPend && !moduleFault && !opErrEvt && !halt_reg && !pfEnd
      |=> isRun)
      else $error("Resume did not continue.");
   jog_end_a: assert property (isRun && jogMode && !anyJog && !halt_reg && !pfEnd
      && !opErrEvt && !hostRise |=> state_reg == ST_DONE)
      else $error("Jog not completed.");
   edge_hold_a: assert property (state_reg == ST_DONE && edgeMode && !gateRise
      |=> state_reg != ST_RUN)
      else $error("Edge mode started without gate rise.");
   op_err_a: assert property (opErrEvt && isRun && !blockAll && !moduleFault && !extAbort
      && !halt_reg && !pfEnd |=> state_reg == ST_INTR && opErr_reg)
      else $error("Operator error not handled.");
   drv_dis_a: assert property (cfg_reg[`TSC_CFG_DRVDIS] && !halt_reg && !pfEnd
      |=> state_reg == ST_DONE && !driveOn_reg)
      else $error("Drive disable did not abort.");
   pos_hold_a: assert property (posReach_reg && !startEvt && !halt_reg && !pfEnd
      |=> posReach_reg)
      else $error("Position reached dropped early.");
   ready_loss_a: assert property (readyLost && !pfEnd
      |=> !ctrl_reg[`TSC_CTRL_HOST])
      else $error("Host mode kept after ready loss.");
   stop_prio_a: assert property (state_reg == ST_INTR && stopBit |=> state_reg != ST_RUN)
      else $error("Resume won over stop.");
endmodule

// ==== tb/tsc_host_model.sv ====
// Host controller model that drives the gate pin and the cyclic ready toggle.
module tsc_host_model (
   input logic core_clk,
   input logic srst,
   input logic gateCmd,
   input logic aliveCmd,
   output logic gatePin,
   output logic readyPin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] tickReg;
   // The ready pin toggles every 16 cycles while alive and freezes when the host dies.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tickReg <= 4'h0;
         readyPin <= 1'b0;
         gatePin <= 1'b0;
      end else begin
         gatePin <= gateCmd;
         tickReg <= tickReg + 4'h1;
         if (aliveCmd && tickReg == 4'hF) begin
            readyPin <= ~readyPin;
         end
      end
   end
endmodule

// ==== tb/tsc_traverse_ctrl_tb_top.sv ====
// Self-checking bench of the traverse state control.
`include "tsc_defines.svh"
module tsc_traverse_ctrl_tb_top;
   import tsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, actPos = 32'h0, rdVal;
   logic pready, pslverr, errVal, gateCmd = 1'b0, aliveCmd = 1'b1, gatePin, readyPin;
   logic moduleFault = 1'b0, driveOn, driveFwd, driveRev, driveCreep, driveDisable;
   logic camTrackEnable, positionReached, outDis = 1'b0, powerFailN = 1'b1;
   tsc_state_t modeState;
   int err_total = 0, n_compared = 0;
   always #2 core_clk = ~core_clk;
   tsc_host_model host_u (.core_clk(core_clk), .srst(srst), .gateCmd(gateCmd),
      .aliveCmd(aliveCmd), .gatePin(gatePin), .readyPin(readyPin));
   tsc_traverse_ctrl #(.READY_LOSS_CYC(50)) dut_u (.core_clk(core_clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .actPos(actPos),
      .moduleFault(moduleFault), .axisSyncGateInput(gatePin), .outputDisableSignal(outDis),
      .powerFailSignalN(powerFailN), .hostCyclicReady(readyPin), .driveOn(driveOn),
      .driveFwd(driveFwd), .driveRev(driveRev), .driveCreep(driveCreep),
      .driveDisable(driveDisable), .camTrackEnable(camTrackEnable),
      .positionReached(positionReached), .modeState(modeState));
   task automatic end_sim();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
      end
   endtask
   // The request is held until pready is sampled high at a rising edge; data is taken there.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdVal = prdata;
      errVal = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic stbit(input int n, input logic v);
      apb(1'b0, `TSC_ADDR_STATUS, 32'h0);
      chk({31'h0, rdVal[n]}, {31'h0, v}, "status bit");
   endtask
   task automatic wst(input tsc_state_t s);
      for (int i = 0; i < 40 && modeState !== s; i++) begin
         @(posedge core_clk);
      end
      chk({28'h0, modeState}, {28'h0, s}, "mode state");
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      chk({28'h0, modeState}, {28'h0, ST_DONE}, "reset state");
      chk({31'h0, driveOn}, 32'h0, "reset drive");
      apb(1'b0, `TSC_ADDR_CFG, 32'h0);
      chk(rdVal, `TSC_CFG_RESET, "cfg reset");
      apb(1'b0, 32'h00000040, 32'h0);
      chk({31'h0, errVal}, 32'h1, "unmapped error");
      wr(`TSC_ADDR_TARGET, 32'hFFFF0000);
      gateCmd <= 1'b1;
      wr(`TSC_ADDR_CTRL, 32'h00000001);
      wst(ST_RUN);
      chk({31'h0, driveOn}, 32'h1, "drive on");
      chk({31'h0, driveRev}, 32'h1, "reverse to target");
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      gateCmd <= 1'b0;
      wst(ST_INTR);
      chk({31'h0, driveOn}, 32'h0, "gate stop drive");
      stbit(`TSC_ST_FICTREACH, 1'b1);
      chk({31'h0, positionReached}, 32'h0, "fictitious no reach");
      gateCmd <= 1'b1;
      wr(`TSC_ADDR_CTRL, 32'h00000004);
      wst(ST_RUN);
      wr(`TSC_ADDR_CTRL, 32'h00000007);
      wst(ST_INTR);
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      wr(`TSC_ADDR_FUNC, 32'h00000001);
      wst(ST_DONE);
      stbit(`TSC_ST_OPERR, 1'b1);
      wr(`TSC_ADDR_CTRL, 32'h00000001);
      wst(ST_RUN);
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      wr(`TSC_ADDR_EXTERR, 32'h00000003);
      wst(ST_DONE);
      wr(`TSC_ADDR_CTRL, 32'h00000068);
      repeat (10) @(posedge core_clk);
      chk({28'h0, modeState}, {28'h0, ST_DONE}, "jog blocked");
      wr(`TSC_ADDR_EXTERR, {27'h0, `TSC_EXT_SUPPLY_DI});
      wst(ST_RUN);
      chk({31'h0, driveCreep}, 32'h1, "creep");
      chk({31'h0, driveFwd}, 32'h1, "jog forward");
      wr(`TSC_ADDR_CTRL, 32'h00000060);
      wst(ST_DONE);
      wr(`TSC_ADDR_EXTERR, 32'h0000002D);
      wr(`TSC_ADDR_CTRL, 32'h00000070);
      repeat (10) @(posedge core_clk);
      chk({28'h0, modeState}, {28'h0, ST_DONE}, "wrong limit");
      wr(`TSC_ADDR_CTRL, 32'h00000068);
      wst(ST_RUN);
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      wr(`TSC_ADDR_EXTERR, 32'h00000000);
      wst(ST_DONE);
      wr(`TSC_ADDR_CTRL, 32'h00000001);
      wst(ST_RUN);
      wr(`TSC_ADDR_CFG, 32'h00000018);
      wst(ST_DONE);
      chk({31'h0, driveDisable}, 32'h1, "drive disable");
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      wr(`TSC_ADDR_CFG, 32'h00000010);
      wr(`TSC_ADDR_TARGET, 32'h00000064);
      wr(`TSC_ADDR_RANGE, 32'h00000005);
      wr(`TSC_ADDR_CTRL, 32'h00000001);
      wst(ST_RUN);
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      actPos <= 32'h00000067;
      wst(ST_DONE);
      chk({31'h0, positionReached}, 32'h1, "pos reached");
      actPos <= 32'h00000000;
      repeat (5) @(posedge core_clk);
      chk({31'h0, positionReached}, 32'h1, "pos held");
      wr(`TSC_ADDR_CTRL, 32'h00000001);
      wst(ST_RUN);
      chk({31'h0, positionReached}, 32'h0, "pos cleared");
      outDis <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk({28'h0, modeState}, {28'h0, ST_RUN}, "disable ignored");
      wr(`TSC_ADDR_CFG, 32'h00000014);
      wst(ST_DONE);
      chk({31'h0, driveDisable}, 32'h1, "host disable drive");
      outDis <= 1'b0;
      wr(`TSC_ADDR_CFG, 32'h00000010);
      wst(ST_RUN);
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      wr(`TSC_ADDR_CFG, 32'h00000011);
      gateCmd <= 1'b0;
      repeat (5) @(posedge core_clk);
      gateCmd <= 1'b1;
      wst(ST_INTR);
      chk({31'h0, driveOn}, 32'h0, "edge stop drive");
      wr(`TSC_ADDR_CTRL, 32'h00000004);
      gateCmd <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk({28'h0, modeState}, {28'h0, ST_INTR}, "no rise");
      gateCmd <= 1'b1;
      wst(ST_RUN);
      wr(`TSC_ADDR_CTRL, 32'h00000000);
      wr(`TSC_ADDR_CFG, 32'h00000010);
      wr(`TSC_ADDR_CTRL, 32'h00000081);
      wst(ST_INTR);
      stbit(`TSC_ST_HOST, 1'b1);
      aliveCmd <= 1'b0;
      repeat (120) @(posedge core_clk);
      stbit(`TSC_ST_HOST, 1'b0);
      powerFailN <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk({28'h0, modeState}, {28'h0, ST_DONE}, "power fail state");
      chk({31'h0, camTrackEnable}, 32'h0, "power fail outputs");
      stbit(`TSC_ST_UNSYNC, 1'b1);
      powerFailN <= 1'b1;
      repeat (6) @(posedge core_clk);
      apb(1'b0, `TSC_ADDR_CTRL, 32'h0);
      chk(rdVal, `TSC_CTRL_RESET, "restart ctrl");
      stbit(`TSC_ST_UNSYNC, 1'b1);
      moduleFault <= 1'b1;
      @(posedge core_clk);
      moduleFault <= 1'b0;
      wr(`TSC_ADDR_CTRL, 32'h00000001);
      repeat (10) @(posedge core_clk);
      stbit(`TSC_ST_HALT, 1'b1);
      chk({28'h0, modeState}, {28'h0, ST_DONE}, "halted");
      chk({31'h0, driveOn}, 32'h0, "halted drive");
      end_sim();
   end
endmodule
